//--- core/eamu_core.sv
/*
  Effective address and memory reference unit: forms the indexed
  address, walks indirect chains, and executes jump, jump to
  subroutine, increment/decrement and skip, load and store.
  Assumes a memory port that takes a held request with one ack pulse,
  returning read data with that ack, and a caller on the same clock.
*/
// Overview of operation
// - Index 00: zero-filled unsigned page-zero displacement
// - Index 01: sign-extended displacement plus PC
// - PC-relative uses the instruction fetch address
// - Index 10: displacement plus accumulator two
// - Index 11: displacement plus accumulator three
// - Register sums keep only bits 1-15
// - Bit 5 selects direct or indirect address
// - Chains start at indexed or vector address
// - Pointer bit 0 chooses final or next
// - No refresh or breaks during a chain
// - Guard adds two/three; halt at sixteen
// - Octal 20-27 pointers written back plus one
// - Continue incremented; flag from original word
// - Octal 30-37 pointers written back minus one
// - Continue decremented; flag from original word
// - Subroutine jump saves PC plus one in accumulator three
// - Jump loads effective address into PC
// - Increment, write back, skip when zero
// - Decrement, write back, skip when zero
// - Load selected accumulator, advance PC one
// - Store selected accumulator, advance PC one
// - PC advances one, or two on skip
`timescale 1ns/1ps
module eamu_core
  import eamu_pkg::*;
#(
  parameter int DW = EAMU_DW,
  parameter int AW = EAMU_AW
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Instruction request
  input wire logic exec_valid,
  input wire logic [15:0] instr,
  input wire logic [14:0] fetch_pc,
  input wire eamu_acc_s acc_in,
  // Interrupt vector chain request
  input wire logic vec_valid,
  input wire logic [14:0] vec_ptr,
  // Memory port
  output eamu_mem_req_s mem,
  input wire logic mem_ack,
  input wire logic [15:0] mem_rdata,
  // Results
  output logic idle,
  output logic done,
  output logic bad_op,
  output logic [14:0] pc_next,
  output eamu_acc_wr_s acc_wr,
  output logic vec_done,
  output logic [14:0] vec_addr,
  output logic halted,
  output logic break_inhibit
);

  // Widths are fixed by the packed types of the package
  if (DW != EAMU_DW || AW != EAMU_AW) begin : g_bad_width
    $error("eamu_core: widths must match the package");
  end

  // Reset synchroniser; only stage two is read
  logic [1:0] rst_sync_r;
  logic rst_n_q;

  // Sequencer and operand registers
  eamu_state_e state_r, state_nxt;
  logic [15:0] instr_r, instr_nxt; // Instruction being run
  logic [14:0] pc_r, pc_nxt; // Fetch address of it
  eamu_acc_s acc_r, acc_nxt; // Accumulators at start
  logic [14:0] ptr_r, ptr_nxt; // Current indirect address
  logic [14:0] link_r, link_nxt; // Address after auto-modify
  logic flag_r, flag_nxt; // Unmodified indirect flag
  logic [4:0] guard_r, guard_nxt; // Chain guard counter
  logic [14:0] ea_r, ea_nxt; // Effective address
  logic vec_r, vec_nxt; // Chain belongs to an interrupt
  logic [15:0] mod_r, mod_nxt; // Modified word to write
  logic skip_r, skip_nxt; // Write-back came out zero

  // Output registers
  eamu_mem_req_s mem_r, mem_nxt;
  logic idle_r, idle_nxt;
  logic done_r, done_nxt;
  logic bad_r, bad_nxt;
  logic [14:0] pcn_r, pcn_nxt;
  eamu_acc_wr_s accw_r, accw_nxt;
  logic vdone_r, vdone_nxt;
  logic [14:0] vaddr_r, vaddr_nxt;
  logic halt_r, halt_nxt;
  logic inhibit_r, inhibit_nxt;

  // Decode helpers
  logic [2:0] opc; // Major opcode
  logic [1:0] fn; // Function or accumulator field
  logic memref; // Opcode is handled here
  logic [14:0] indexed; // Indexed address of instr_r
  logic [15:0] acc_pick; // Accumulator named by fn
  eamu_state_e op_state; // Operand step for this opcode
  logic taken; // Memory accepted our request
  logic auto_inc; // Pointer in the increment block
  logic auto_dec; // Pointer in the decrement block
  logic [15:0] rd_mod; // Read word plus or minus one
  logic step_now; // A pointer word is complete
  logic step_flag; // Its indirect flag
  logic [14:0] step_addr; // Its address field
  logic [4:0] step_guard; // Guard after this read

  // Indexed address former
  eamu_index_calc u_index (
    .idx (instr_r[IDX_HI:IDX_LO]),
    .disp (instr_r[DISP_HI:DISP_LO]),
    .pc (pc_r),
    .accumulator_two (acc_r.accumulator_two),
    .accumulator_three (acc_r.accumulator_three),
    .indexed (indexed)
  );

  // Reset release through two flops
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'h1};
    end
  end
  assign rst_n_q = rst_sync_r[1];

  // Field decode and accumulator select
  always_comb begin
    opc = instr_r[OPC_HI:OPC_LO];
    fn = instr_r[FN_HI:FN_LO];
    memref = (opc == OP_FLOW) || (opc == OP_LOAD) || (opc == OP_STORE);
    // Accumulator zero sits highest in the packed word
    acc_pick = acc_r[EAMU_DW * (ACC3_SEL - fn) +: EAMU_DW];
    if (opc == OP_STORE) begin
      op_state = ST_OP_WR;
    end else if (opc == OP_LOAD || fn == FN_ISZ || fn == FN_DSZ) begin
      op_state = ST_OP_RD;
    end else begin
      op_state = ST_FINISH;
    end
  end

  // Auto-modify detection and the modified word
  always_comb begin
    taken = mem_r.req && mem_ack;
    auto_inc = (ptr_r[14:3] == AUTO_INC_BLK);
    auto_dec = (ptr_r[14:3] == AUTO_DEC_BLK);
    // Flow functions decrement only for the DSZ code
    if ((state_r == ST_IND_RD && auto_dec) || (state_r == ST_OP_RD && fn == FN_DSZ)) begin
      rd_mod = mem_rdata - WORD_ONE;
    end else begin
      rd_mod = mem_rdata + WORD_ONE;
    end
  end

  // One pointer word finishes: plain read, or auto-modify write-back
  always_comb begin
    step_now = taken && ((state_r == ST_IND_WB) || (state_r == ST_IND_RD && !auto_inc && !auto_dec));
    if (state_r == ST_IND_WB) begin
      step_flag = flag_r;
      step_addr = link_r;
      step_guard = guard_r + GUARD_STEP_AUTO;
    end else begin
      step_flag = mem_rdata[PTR_FLAG_POS];
      step_addr = mem_rdata[14:0];
      step_guard = guard_r + GUARD_STEP;
    end
  end

  // Sequencer: next values of every register but the memory port, idle and inhibit
  always_comb begin
    state_nxt = state_r;
    instr_nxt = instr_r;
    pc_nxt = pc_r;
    acc_nxt = acc_r;
    ptr_nxt = ptr_r;
    link_nxt = link_r;
    flag_nxt = flag_r;
    guard_nxt = guard_r;
    ea_nxt = ea_r;
    vec_nxt = vec_r;
    mod_nxt = mod_r;
    skip_nxt = skip_r;
    done_nxt = 1'h0;
    bad_nxt = 1'h0;
    vdone_nxt = 1'h0;
    pcn_nxt = pcn_r;
    accw_nxt = accw_r;
    accw_nxt.we = 1'h0;
    vaddr_nxt = vaddr_r;
    halt_nxt = halt_r;
    case (state_r)
      ST_IDLE, ST_HALTED: begin
        // Interrupt chains take precedence, and only they leave a halt
        if (vec_valid) begin
          ptr_nxt = vec_ptr;
          guard_nxt = 5'h00;
          vec_nxt = 1'h1;
          halt_nxt = 1'h0;
          state_nxt = ST_IND_RD;
        end else if (exec_valid && state_r == ST_IDLE) begin
          instr_nxt = instr;
          pc_nxt = fetch_pc;
          acc_nxt = acc_in;
          vec_nxt = 1'h0;
          state_nxt = ST_ADDR;
        end
      end
      ST_ADDR: begin
        if (!memref) begin
          // Not ours: report and leave the PC alone
          bad_nxt = 1'h1;
          done_nxt = 1'h1;
          pcn_nxt = pc_r;
          state_nxt = ST_IDLE;
        end else if (instr_r[IND_POS]) begin
          ptr_nxt = indexed;
          guard_nxt = 5'h00;
          state_nxt = ST_IND_RD;
        end else begin
          ea_nxt = indexed;
          state_nxt = op_state;
        end
      end
      ST_IND_RD: begin
        // Auto-modify pointers become a read-modify-write
        if (taken && (auto_inc || auto_dec)) begin
          mod_nxt = rd_mod;
          link_nxt = rd_mod[14:0];
          flag_nxt = mem_rdata[PTR_FLAG_POS];
          state_nxt = ST_IND_WB;
        end
      end
      ST_IND_WB: begin
        // Chain step is handled below once the write is taken
      end
      ST_OP_RD: begin
        if (taken) begin
          if (opc == OP_LOAD) begin
            accw_nxt.we = 1'h1;
            accw_nxt.sel = fn;
            accw_nxt.data = mem_rdata;
            pcn_nxt = pc_r + PC_STEP;
            done_nxt = 1'h1;
            state_nxt = ST_IDLE;
          end else begin
            mod_nxt = rd_mod;
            skip_nxt = (rd_mod == WORD_ZERO);
            state_nxt = ST_OP_WR;
          end
        end
      end
      ST_OP_WR: begin
        if (taken) begin
          if (opc != OP_STORE && skip_r) begin
            pcn_nxt = pc_r + PC_SKIP;
          end else begin
            pcn_nxt = pc_r + PC_STEP;
          end
          done_nxt = 1'h1;
          state_nxt = ST_IDLE;
        end
      end
      ST_FINISH: begin
        if (fn == FN_JSR) begin
          // Return address is the word after the jump
          accw_nxt.we = 1'h1;
          accw_nxt.sel = ACC3_SEL;
          accw_nxt.data = {1'h0, pc_r + PC_STEP};
        end
        pcn_nxt = ea_r;
        done_nxt = 1'h1;
        state_nxt = ST_IDLE;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
    // A completed pointer word ends or extends the chain
    if (step_now) begin
      guard_nxt = step_guard;
      if (!step_flag) begin
        // Final address reached
        if (vec_r) begin
          vaddr_nxt = step_addr;
          vdone_nxt = 1'h1;
          state_nxt = ST_IDLE;
        end else begin
          ea_nxt = step_addr;
          state_nxt = op_state;
        end
      end else if (step_guard >= GUARD_LIMIT) begin
        halt_nxt = 1'h1;
        state_nxt = ST_HALTED;
      end else begin
        ptr_nxt = step_addr;
        state_nxt = ST_IND_RD;
      end
    end
  end

  // Memory request follows the next state; it drops for one cycle
  // after every ack so that one ack can never serve two requests
  always_comb begin
    mem_nxt.req = !taken && (state_nxt == ST_IND_RD || state_nxt == ST_IND_WB ||
                             state_nxt == ST_OP_RD || state_nxt == ST_OP_WR);
    mem_nxt.we = (state_nxt == ST_IND_WB) || (state_nxt == ST_OP_WR);
    if (state_nxt == ST_IND_RD || state_nxt == ST_IND_WB) begin
      mem_nxt.addr = ptr_nxt;
    end else begin
      mem_nxt.addr = ea_nxt;
    end
    if (state_nxt == ST_OP_WR && opc == OP_STORE) begin
      mem_nxt.wdata = acc_pick;
    end else begin
      mem_nxt.wdata = mod_nxt;
    end
    idle_nxt = (state_nxt == ST_IDLE);
    inhibit_nxt = (state_nxt == ST_IND_RD) || (state_nxt == ST_IND_WB);
  end

  // Sequencer state
  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Instruction and operand capture
  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      instr_r <= 16'h0000;
      pc_r <= 15'h0000;
      acc_r <= '0;
      ea_r <= 15'h0000;
      mod_r <= 16'h0000;
      skip_r <= 1'h0;
    end else begin
      instr_r <= instr_nxt;
      pc_r <= pc_nxt;
      acc_r <= acc_nxt;
      ea_r <= ea_nxt;
      mod_r <= mod_nxt;
      skip_r <= skip_nxt;
    end
  end

  // Indirect chain bookkeeping
  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ptr_r <= 15'h0000;
      link_r <= 15'h0000;
      flag_r <= 1'h0;
      guard_r <= 5'h00;
      vec_r <= 1'h0;
    end else begin
      ptr_r <= ptr_nxt;
      link_r <= link_nxt;
      flag_r <= flag_nxt;
      guard_r <= guard_nxt;
      vec_r <= vec_nxt;
    end
  end

  // Memory port and status outputs
  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      mem_r <= '0;
      idle_r <= 1'h0;
      inhibit_r <= 1'h0;
      halt_r <= 1'h0;
    end else begin
      mem_r <= mem_nxt;
      idle_r <= idle_nxt;
      inhibit_r <= inhibit_nxt;
      halt_r <= halt_nxt;
    end
  end

  // Result outputs
  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      done_r <= 1'h0;
      bad_r <= 1'h0;
      pcn_r <= 15'h0000;
      accw_r <= '0;
      vdone_r <= 1'h0;
      vaddr_r <= 15'h0000;
    end else begin
      done_r <= done_nxt;
      bad_r <= bad_nxt;
      pcn_r <= pcn_nxt;
      accw_r <= accw_nxt;
      vdone_r <= vdone_nxt;
      vaddr_r <= vaddr_nxt;
    end
  end

  // Drive ports from their registers
  assign mem = mem_r;
  assign idle = idle_r;
  assign done = done_r;
  assign bad_op = bad_r;
  assign pc_next = pcn_r;
  assign acc_wr = accw_r;
  assign vec_done = vdone_r;
  assign vec_addr = vaddr_r;
  assign halted = halt_r;
  assign break_inhibit = inhibit_r;

endmodule

//--- core/eamu_pkg.sv
/*
  Shared constants and types of the effective address and memory
  reference unit: instruction fields, opcodes, guard counts, states.
  Assumes bit 0 of a word is its most significant bit, so word bit k
  sits at vector index 15-k.
*/
package eamu_pkg;

  // Word and address widths
  localparam int EAMU_DW = 16;
  localparam int EAMU_AW = 15;

  // Instruction field positions (vector indices)
  localparam int OPC_HI = 15;
  localparam int OPC_LO = 13;
  localparam int FN_HI = 12;
  localparam int FN_LO = 11;
  localparam int IND_POS = 10;
  localparam int IDX_HI = 9;
  localparam int IDX_LO = 8;
  localparam int DISP_HI = 7;
  localparam int DISP_LO = 0;
  // Word bit 0: indirect flag of a pointer word
  localparam int PTR_FLAG_POS = 15;

  // Major opcodes in bits 0 to 2
  localparam logic [2:0] OP_FLOW = 3'h0;
  localparam logic [2:0] OP_LOAD = 3'h1;
  localparam logic [2:0] OP_STORE = 3'h2;

  // Flow functions in bits 3 and 4
  localparam logic [1:0] FN_JUMP = 2'h0;
  localparam logic [1:0] FN_JSR = 2'h1;
  localparam logic [1:0] FN_ISZ = 2'h2;
  localparam logic [1:0] FN_DSZ = 2'h3;

  // Index modes in bits 6 and 7
  localparam logic [1:0] IDX_PAGE0 = 2'h0;
  localparam logic [1:0] IDX_PC = 2'h1;
  localparam logic [1:0] IDX_AC2 = 2'h2;
  localparam logic [1:0] IDX_AC3 = 2'h3;

  // Auto-modify blocks, octal 20-27 and 30-37, as address[14:3]
  localparam logic [11:0] AUTO_INC_BLK = 12'h002;
  localparam logic [11:0] AUTO_DEC_BLK = 12'h003;

  // Guard counter steps and halt limit
  localparam logic [4:0] GUARD_STEP = 5'h02;
  localparam logic [4:0] GUARD_STEP_AUTO = 5'h03;
  localparam logic [4:0] GUARD_LIMIT = 5'h10;

  // Program counter advances and word arithmetic
  localparam logic [14:0] PC_STEP = 15'h0001;
  localparam logic [14:0] PC_SKIP = 15'h0002;
  localparam logic [15:0] WORD_ONE = 16'h0001;
  localparam logic [15:0] WORD_ZERO = 16'h0000;
  localparam logic [1:0] ACC3_SEL = 2'h3;

  // Sequencer states, Gray coded along the usual path
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ADDR = 3'h1,
    ST_IND_RD = 3'h3,
    ST_IND_WB = 3'h2,
    ST_OP_RD = 3'h6,
    ST_OP_WR = 3'h7,
    ST_FINISH = 3'h5,
    ST_HALTED = 3'h4
  } eamu_state_e;

  // One request on the memory port
  typedef struct packed {
    logic req;
    logic we;
    logic [14:0] addr;
    logic [15:0] wdata;
  } eamu_mem_req_s;

  // Accumulator contents as seen by the unit
  typedef struct packed {
    logic [15:0] ac0;
    logic [15:0] ac1;
    logic [15:0] accumulator_two;
    logic [15:0] accumulator_three;
  } eamu_acc_s;

  // Accumulator write-back
  typedef struct packed {
    logic we;
    logic [1:0] sel;
    logic [15:0] data;
  } eamu_acc_wr_s;

endpackage

//--- core/eamu_index_calc.sv
/*
  Indexed address former: widens the displacement to the 15-bit
  intermediate value and adds the selected base register.
  Purely combinational; inputs come from registers of the same clock.
*/
`timescale 1ns/1ps
module eamu_index_calc
  import eamu_pkg::*;
(
  // Instruction fields
  input wire logic [1:0] idx,
  input wire logic [7:0] disp,
  // Base registers
  input wire logic [14:0] pc,
  input wire logic [15:0] accumulator_two,
  input wire logic [15:0] accumulator_three,
  // Result
  output logic [14:0] indexed
);

  logic [14:0] inter; // Intermediate value
  logic [14:0] base; // Register added to it
  logic [15:0] sum; // One guard bit for the carry

  // Widen the displacement and pick the base; bit 0 of a base never enters the sum
  always_comb begin
    inter = {{7{disp[7]}}, disp};
    case (idx)
      IDX_AC2: base = accumulator_two[14:0];
      IDX_AC3: base = accumulator_three[14:0];
      default: base = pc;
    endcase
    sum = {1'h0, base} + {1'h0, inter};
    indexed = sum[14:0];
    // Page zero ignores the base and the sign
    if (idx == IDX_PAGE0) begin
      indexed = {7'h00, disp};
    end
  end

endmodule

//--- sim/eamu_core_sva.sv
/*
  Port checker for eamu_core: address forming, write-backs, results.
  Assumes it is bound to eamu_core and sees only its ports.
*/
`timescale 1ns/1ps
module eamu_core_sva
  import eamu_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Requests
  input wire logic exec_valid,
  input wire logic [15:0] instr,
  input wire logic [14:0] fetch_pc,
  input wire eamu_acc_s acc_in,
  input wire logic vec_valid,
  input wire logic [14:0] vec_ptr,
  // Memory port
  input wire eamu_mem_req_s mem,
  input wire logic mem_ack,
  input wire logic [15:0] mem_rdata,
  // Results
  input wire logic idle,
  input wire logic done,
  input wire logic halted,
  input wire logic break_inhibit,
  input wire logic [14:0] pc_next,
  input wire eamu_acc_wr_s acc_wr
);
  logic take; // Request accepted this edge
  logic [15:0] ins_r; // Accepted instruction
  logic [14:0] pc_r; // Its fetch address
  eamu_acc_s acc_r; // Its accumulators
  logic [15:0] wr_r; // Last word written
  logic [14:0] rd_a_r; // Last read address
  logic [15:0] rd_d_r; // Last read word
  logic [14:0] sext; // Sign-extended displacement
  logic [14:0] ea_x; // Expected indexed address
  logic [15:0] acc_sel; // Accumulator named by bits 3-4
  logic rd_ack; // A read answered now
  assign take = idle && exec_valid && !vec_valid;
  assign rd_ack = mem_ack && !mem.we;
  assign sext = {{7{ins_r[7]}}, ins_r[7:0]};
  assign acc_sel = acc_r[63 - 16 * ins_r[12:11] -: 16];
  // Capture what was accepted, so results can be judged later
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ins_r <= 16'h0000;
      pc_r <= 15'h0000;
      acc_r <= '0;
    end else if (take) begin
      ins_r <= instr;
      pc_r <= fetch_pc;
      acc_r <= acc_in;
    end
  end
  // Track memory traffic for write-back checks
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      wr_r <= 16'h0000;
      rd_a_r <= 15'h0000;
      rd_d_r <= 16'h0000;
    end else if (mem_ack && mem.we) begin
      wr_r <= mem.wdata;
    end else if (rd_ack) begin
      rd_a_r <= mem.addr;
      rd_d_r <= mem_rdata;
    end
  end
  // Own model of the index adder; bit 0 of a register never enters the sum
  always_comb begin
    case (ins_r[9:8])
      IDX_PAGE0: ea_x = {7'h00, ins_r[7:0]};
      IDX_PC: ea_x = sext + pc_r;
      IDX_AC2: ea_x = sext + acc_r.accumulator_two[14:0];
      default: ea_x = sext + acc_r.accumulator_three[14:0];
    endcase
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  // Read-modify-write: gap cycle, then a write to the same place
  sequence s_wb(logic [15:0] d);
    !mem.req ##1 mem.req && mem.we && mem.addr == rd_a_r && mem.wdata == d;
  endsequence
  // Direct jump: two busy cycles, then the answer
  sequence s_dir;
    !idle ##1 !idle ##1 done && idle;
  endsequence
  req_hold_a: assert property (mem.req && !mem_ack |=> mem.req && $stable(mem))
    else $error("req not held");
  inc_wb_a: assert property (break_inhibit && rd_ack && mem.addr[14:3] == AUTO_INC_BLK |=> s_wb(rd_d_r + WORD_ONE))
    else $error("inc write-back");
  dec_wb_a: assert property (break_inhibit && rd_ack && mem.addr[14:3] == AUTO_DEC_BLK |=> s_wb(rd_d_r - WORD_ONE))
    else $error("dec write-back");
  rmw_wb_a: assert property (!break_inhibit && rd_ack && ins_r[15:12] == {OP_FLOW, 1'b1}
    |=> s_wb(ins_r[11] ? rd_d_r - WORD_ONE : rd_d_r + WORD_ONE))
    else $error("skip write-back");
  skip_pc_a: assert property (done && ins_r[15:12] == {OP_FLOW, 1'b1}
    |-> pc_next == pc_r + ((wr_r == WORD_ZERO) ? PC_SKIP : PC_STEP))
    else $error("skip advance");
  jump_ea_a: assert property (done && ins_r[15:10] == {OP_FLOW, FN_JUMP, 1'b0} |-> pc_next == ea_x)
    else $error("jump target");
  jsr_save_a: assert property (done && ins_r[15:10] == {OP_FLOW, FN_JSR, 1'b0}
    |-> pc_next == ea_x && acc_wr.we && acc_wr.sel == ACC3_SEL && acc_wr.data == {1'b0, pc_r + PC_STEP})
    else $error("link save");
  ldst_pc_a: assert property (done && (ins_r[15:13] == OP_LOAD || ins_r[15:13] == OP_STORE)
    |-> pc_next == pc_r + PC_STEP && acc_wr.we == (ins_r[15:13] == OP_LOAD))
    else $error("load/store pc");
  load_data_a: assert property (done && ins_r[15:13] == OP_LOAD |-> acc_wr.sel == ins_r[12:11] && acc_wr.data == rd_d_r)
    else $error("load data");
  store_data_a: assert property (mem.req && mem.we && !break_inhibit && ins_r[15:13] == OP_STORE
    |-> mem.wdata == acc_sel && mem.addr == ea_x | ins_r[10])
    else $error("store data");
  jump_lat_a: assert property (take && instr[15:10] == {OP_FLOW, FN_JUMP, 1'b0} |=> s_dir)
    else $error("jump latency");
  vec_start_a: assert property ((idle || halted) && vec_valid
    |=> break_inhibit && mem.req && !mem.we && mem.addr == $past(vec_ptr))
    else $error("vector start");
endmodule

bind eamu_core eamu_core_sva i_eamu_core_sva (.*);

//--- sim/eamu_mem_model.sv
/*
  Memory partner of eamu_core: a word store that acks held requests.
  Assumes one clock; the bench preloads words and sets the wait.
*/
`timescale 1ns/1ps
module eamu_mem_model
  import eamu_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Request and wait setting
  input wire eamu_mem_req_s mem,
  input wire logic [3:0] lat,
  // Answer
  output logic mem_ack,
  output logic [15:0] mem_rdata
);
  logic [15:0] m [0:32767]; // Word store
  logic [3:0] wait_r; // Wait cycles spent
  // One ack per request; data is only good in the ack cycle
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      mem_ack <= 1'b0;
      wait_r <= 4'h0;
      mem_rdata <= 16'h5A5A;
    end else if (mem.req && !mem_ack && wait_r >= lat) begin
      mem_ack <= 1'b1;
      wait_r <= 4'h0;
      if (mem.we) m[mem.addr] <= mem.wdata;
      else mem_rdata <= m[mem.addr];
    end else begin
      // Toggle so a late sample never sees the old word
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem.req && !mem_ack) wait_r <= wait_r + 4'h1;
    end
  end
endmodule

//--- sim/test_effective_address_memref_unit.sv
/*
  Bench for eamu_core: jumps, links, loads, stores, skips, chains.
  Assumes eamu_mem_model as memory and a 25 MHz clock.
*/
`timescale 1ns/1ps
module test_effective_address_memref_unit;
  import eamu_pkg::*;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic exec_valid = 1'b0;
  logic [15:0] instr = 16'h0000;
  logic [14:0] fetch_pc = 15'h0000;
  eamu_acc_s acc_in = '0;
  logic vec_valid = 1'b0;
  logic [14:0] vec_ptr = 15'h0000;
  logic [3:0] lat = 4'h0; // Memory wait cycles
  eamu_mem_req_s mem;
  logic mem_ack, idle, done, bad_op, vec_done, halted, break_inhibit;
  logic [15:0] mem_rdata;
  logic [14:0] pc_next, vec_addr;
  eamu_acc_wr_s acc_wr, wr_seen; // wr_seen: write-back at done
  int n_mismatch = 0;
  int cmp_count = 0;
  int n_rd = 0; // Reads answered so far
  eamu_core i_eamu_core (.clock, .rstn, .exec_valid, .instr, .fetch_pc, .acc_in, .vec_valid, .vec_ptr, .mem,
    .mem_ack, .mem_rdata, .idle, .done, .bad_op, .pc_next, .acc_wr, .vec_done, .vec_addr, .halted, .break_inhibit);
  eamu_mem_model i_eamu_mem_model (.clock, .rstn, .mem, .lat, .mem_ack, .mem_rdata);
  initial begin
    forever #20 clock = ~clock;
  end
  always @(posedge clock) if (mem_ack && !mem.we) n_rd++;
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Present one instruction once idle; wait for done or a halt
  task automatic run(input logic [15:0] ins, input logic [14:0] pc);
    int n;
    n = 0;
    while (idle !== 1'b1) begin @(posedge clock); #1; end
    instr = ins;
    fetch_pc = pc;
    exec_valid = 1'b1;
    @(posedge clock); #1;
    exec_valid = 1'b0;
    while (done !== 1'b1 && halted !== 1'b1 && n < 300) begin @(posedge clock); #1; n++; end
    wr_seen = acc_wr;
    chk("answered", {14'h0000, bad_op, n < 300}, {14'h0000, ins[15:13] > OP_STORE, 1'b1});
  endtask
  // Every index mode; bit 0 of a base ignored, sums wrap
  task automatic t_jump();
    acc_in = {16'hA001, 16'hB002, 16'h8100, 16'h0005};
    run({OP_FLOW, FN_JUMP, 1'b0, IDX_PAGE0, 8'hF0}, 15'h1000);
    chk("jmp page0", {1'b0, pc_next}, 16'h00F0);
    run({OP_FLOW, FN_JUMP, 1'b0, IDX_PC, 8'hF0}, 15'h1000);
    chk("jmp pc", {1'b0, pc_next}, 16'h0FF0);
    run({OP_FLOW, FN_JUMP, 1'b0, IDX_AC2, 8'h7F}, 15'h1000);
    chk("jmp ac2", {1'b0, pc_next}, 16'h017F);
    run({OP_FLOW, FN_JUMP, 1'b0, IDX_AC3, 8'hFC}, 15'h1000);
    chk("jmp ac3", {1'b0, pc_next}, 16'h0001);
    run({OP_FLOW, FN_JSR, 1'b0, IDX_PC, 8'h10}, 15'h7FFF);
    chk("jsr pc", {1'b0, pc_next}, 16'h000F);
    chk("jsr link", wr_seen.data, 16'h0000);
    chk("jsr sel", {13'h0000, wr_seen.we, wr_seen.sel}, 16'h0007);
    run(16'h6000, 15'h0700);
    chk("bad pc", {1'b0, pc_next}, 16'h0700);
  endtask
  // Store each accumulator, then load it back
  task automatic t_ldst();
    logic [15:0] v;
    for (int s = 0; s < 4; s++) begin
      v = acc_in[63 - 16 * s -: 16];
      run({OP_STORE, s[1:0], 1'b0, IDX_PAGE0, 8'h80 + s[7:0]}, 15'h0200);
      chk("stored", i_eamu_mem_model.m[15'h0080 + s[14:0]], v);
      chk("store pc", {1'b0, pc_next}, 16'h0201);
      run({OP_LOAD, s[1:0], 1'b0, IDX_PAGE0, 8'h80 + s[7:0]}, 15'h0300);
      chk("load data", wr_seen.data, v);
      chk("load sel", {13'h0000, wr_seen.we, wr_seen.sel}, {13'h0000, 1'b1, s[1:0]});
      chk("load pc", {1'b0, pc_next}, 16'h0301);
    end
  endtask
  // Increment and decrement, skipping only on a zero result
  task automatic t_skip();
    logic [15:0] iv [4] = '{16'hFFFF, 16'h0005, 16'h0001, 16'h0000};
    logic [15:0] w;
    for (int k = 0; k < 4; k++) begin
      lat = k[3:0];
      i_eamu_mem_model.m['h90] = iv[k];
      w = (k < 2) ? iv[k] + 16'h0001 : iv[k] - 16'h0001;
      run({OP_FLOW, (k < 2) ? FN_ISZ : FN_DSZ, 1'b0, IDX_PAGE0, 8'h90}, 15'h0400);
      chk("skip word", i_eamu_mem_model.m['h90], w);
      chk("skip pc", {1'b0, pc_next}, (w == 16'h0000) ? 16'h0402 : 16'h0401);
    end
  endtask
  // Plain, auto-increment and auto-decrement chains with slow memory
  task automatic t_chain();
    lat = 4'h2;
    i_eamu_mem_model.m['h40] = 16'h8050;
    i_eamu_mem_model.m['h50] = 16'h1234;
    i_eamu_mem_model.m['h10] = 16'h7FFF;
    i_eamu_mem_model.m['h18] = 16'h8000;
    i_eamu_mem_model.m['h7FFF] = 16'h0123;
    run({OP_FLOW, FN_JUMP, 1'b1, IDX_PAGE0, 8'h40}, 15'h0500);
    chk("chain", {1'b0, pc_next}, 16'h1234);
    run({OP_FLOW, FN_JUMP, 1'b1, IDX_PAGE0, 8'h10}, 15'h0500);
    chk("inc word", i_eamu_mem_model.m['h10], 16'h8000);
    chk("inc final", {1'b0, pc_next}, 16'h0000);
    run({OP_FLOW, FN_JUMP, 1'b1, IDX_PAGE0, 8'h18}, 15'h0500);
    chk("dec word", i_eamu_mem_model.m['h18], 16'h7FFF);
    chk("dec final", {1'b0, pc_next}, 16'h0123);
  endtask
  // Endless chain halts after eight reads; a vector chain restarts
  task automatic t_guard();
    int n;
    int r0;
    lat = 4'h0;
    i_eamu_mem_model.m['h60] = 16'h8060;
    r0 = n_rd;
    run({OP_FLOW, FN_JUMP, 1'b1, IDX_PAGE0, 8'h60}, 15'h0600);
    chk("halted", {15'h0000, halted}, 16'h0001);
    chk("guard reads", 16'(n_rd - r0), 16'h0008);
    vec_ptr = 15'h0040;
    vec_valid = 1'b1;
    @(posedge clock); #1;
    vec_valid = 1'b0;
    n = 0;
    while (vec_done !== 1'b1 && n < 300) begin @(posedge clock); #1; n++; end
    chk("vec addr", {1'b0, vec_addr}, 16'h1234);
    chk("restarted", {15'h0000, halted}, 16'h0000);
  endtask
  initial begin
    repeat (8) @(posedge clock);
    #1 rstn = 1'b1;
    @(posedge clock); #1;
    t_jump();
    t_ldst();
    t_skip();
    t_chain();
    t_guard();
    stop_test();
  end
  // About 50000 cycles, far beyond the few hundred the tests need
  initial begin
    #2000000;
    n_mismatch++;
    stop_test();
  end
endmodule
